// [hdl/acs_result_mem.v]
// eight-entry result store with registered read port
`timescale 1ns/1ps
module acs_result_mem (
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire        wr_en_in,
   input  wire [2:0]  wr_addr_in,
   input  wire [9:0]  wr_data_in,
   input  wire [2:0]  rd_addr_in,
   output reg  [9:0]  rd_data_out
);
   reg [9:0] mem_q [0:7];
   integer i;

   // write port and registered read
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         for (i = 0; i < 8; i = i + 1) begin
            mem_q[i] <= 10'h000;
         end
         rd_data_out <= 10'h000;
      end else begin
         if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= mem_q[rd_addr_in];
      end
   end
endmodule // acs_result_mem

// [hdl/acs_scheduler.v]
// conversion scheduler: mode and channel mask registers, pass timing, channel sequencer
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_scheduler (
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   input  wire [7:0]  reg_addr_in,
   input  wire [7:0]  reg_wdata_in,
   output reg  [7:0]  reg_rdata_out,
   output wire        conv_start_out,
   output reg  [2:0]  conv_chan_out,
   input  wire        conv_done_in,
   input  wire [9:0]  conv_data_in,
   input  wire [7:0]  limit_fault_in,
   output wire        alert_out,
   output wire        busy_out
);
   // pass states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_PICK = 2'b01;
   localparam [1:0] ST_CONV = 2'b10;

   // intervals in clock cycles; the products are 32 bits and all fit the timer width
   localparam [31:0] IDLE_FULL   = `ACS_IDLE_CYCLES;
   localparam [31:0] FINE_FULL_1 = `ACS_FINE_US_1 * `ACS_CLK_PER_US;
   localparam [31:0] FINE_FULL_2 = `ACS_FINE_US_2 * `ACS_CLK_PER_US;
   localparam [31:0] FINE_FULL_3 = `ACS_FINE_US_3 * `ACS_CLK_PER_US;
   localparam [31:0] FINE_FULL_4 = `ACS_FINE_US_4 * `ACS_CLK_PER_US;
   localparam [31:0] FINE_FULL_5 = `ACS_FINE_US_5 * `ACS_CLK_PER_US;
   localparam [31:0] FINE_FULL_6 = `ACS_FINE_US_6 * `ACS_CLK_PER_US;
   localparam [31:0] FINE_FULL_7 = `ACS_FINE_US_7 * `ACS_CLK_PER_US;
   localparam [`ACS_CNT_W-1:0] IDLE_CNT = IDLE_FULL[`ACS_CNT_W-1:0];

   reg                  mode_q;
   reg [7:0]            mask_q;
   reg [2:0]            fine_q;
   reg [1:0]            state_q;
   reg [1:0]            state_d;
   reg [`ACS_CNT_W-1:0] wait_q;
   reg [`ACS_CNT_W-1:0] period;
   reg [2:0]            chan_q;
   reg                  rd_res_q;
   reg                  rd_dis_q;
   reg [7:0]            dir_q;
   wire [9:0]           mem_rdata;
   wire                 any_en;
   wire                 timer_hit;
   wire                 wr_res;

   // idle period select, fine setting first
   always @* begin
      case (fine_q)
         3'h1: period = FINE_FULL_1[`ACS_CNT_W-1:0];
         3'h2: period = FINE_FULL_2[`ACS_CNT_W-1:0];
         3'h3: period = FINE_FULL_3[`ACS_CNT_W-1:0];
         3'h4: period = FINE_FULL_4[`ACS_CNT_W-1:0];
         3'h5: period = FINE_FULL_5[`ACS_CNT_W-1:0];
         3'h6: period = FINE_FULL_6[`ACS_CNT_W-1:0];
         3'h7: period = FINE_FULL_7[`ACS_CNT_W-1:0];
         default: period = IDLE_CNT;
      endcase
   end

   // all channels masked: the loop stays idle
   assign any_en    = ~&mask_q;
   assign timer_hit = (wait_q == {`ACS_CNT_W{1'b0}});

   // register writes; reserved bits of mode ignored
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         mode_q <= `ACS_RESET_MODE;
         mask_q <= `ACS_RESET_MASK;
         fine_q <= `ACS_RESET_FINE;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `ACS_ADDR_MODE) begin
            mode_q <= reg_wdata_in[`ACS_BIT_MODE];
         end
         if (reg_addr_in == `ACS_ADDR_MASK) begin
            mask_q <= reg_wdata_in;
         end
         if (reg_addr_in == `ACS_ADDR_FINE) begin
            fine_q <= reg_wdata_in[2:0];
         end
      end
   end

   // pass sequencer next state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (timer_hit && any_en) begin
               state_d = ST_PICK;
            end
         end
         ST_PICK: begin
            if (mask_q[chan_q]) begin
               state_d = (chan_q == `ACS_CHAN_LAST) ? ST_IDLE : ST_PICK;
            end else begin
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            // any latency is accepted, the done pulse ends the slot
            if (conv_done_in) begin
               state_d = (chan_q == `ACS_CHAN_LAST) ? ST_IDLE : ST_PICK;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // state, channel pointer, interval timer
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         chan_q  <= 3'h0;
         wait_q  <= {`ACS_CNT_W{1'b0}};
      end else begin
         state_q <= state_d;
         if ((state_q == ST_PICK && mask_q[chan_q]) ||
             (state_q == ST_CONV && conv_done_in)) begin
            chan_q <= chan_q + 3'h1;
         end
         // a new rate applies from the end of a pass, never mid-interval
         if (state_q == ST_IDLE) begin
            if (!timer_hit) begin
               wait_q <= wait_q - {{(`ACS_CNT_W-1){1'b0}}, 1'b1};
            end
         end else if (state_d == ST_IDLE) begin
            // fine rate wins over mode bit
            if (fine_q != 3'h0) begin
               wait_q <= period;
            end else if (mode_q) begin
               wait_q <= {`ACS_CNT_W{1'b0}};
            end else begin
               wait_q <= IDLE_CNT;
            end
         end
      end
   end

   // start pulse held one cycle on entry to conversion
   assign conv_start_out = (state_q == ST_PICK) && !mask_q[chan_q];
   assign busy_out       = (state_q != ST_IDLE);

   // channel id registered for the converter
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         conv_chan_out <= 3'h0;
      end else if (conv_start_out) begin
         conv_chan_out <= chan_q;
      end
   end

   assign wr_res = (state_q == ST_CONV) && conv_done_in && !mask_q[chan_q];

   acs_result_mem u_mem (
      .clk_in      (clk_in),
      .nrst_in     (nrst_in),
      .wr_en_in    (wr_res),
      .wr_addr_in  (chan_q),
      .wr_data_in  (conv_data_in),
      .rd_addr_in  (reg_addr_in[2:0]),
      .rd_data_out (mem_rdata)
   );

   // read side captured alongside the memory read
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         rd_res_q <= 1'b0;
         rd_dis_q <= 1'b0;
         dir_q    <= 8'h00;
      end else begin
         rd_res_q <= reg_rd_in && (reg_addr_in >= `ACS_ADDR_RESULT_BASE) &&
                     (reg_addr_in <= `ACS_ADDR_RESULT_LAST);
         rd_dis_q <= mask_q[reg_addr_in[2:0]];
         if (reg_rd_in) begin
            case (reg_addr_in)
               `ACS_ADDR_MODE: dir_q <= {7'h00, mode_q};
               `ACS_ADDR_MASK: dir_q <= mask_q;
               `ACS_ADDR_FINE: dir_q <= {5'h00, fine_q};
               default:        dir_q <= 8'h00;
            endcase
         end else begin
            dir_q <= 8'h00;
         end
      end
   end

   // read data mux; results give top eight bits of ten
   always @* begin
      if (rd_res_q) begin
         reg_rdata_out = rd_dis_q ? 8'h00 : mem_rdata[9:2];
      end else begin
         reg_rdata_out = dir_q;
      end
   end

   // mask limit faults of disabled channels
   assign alert_out = |(limit_fault_in & ~mask_q);
endmodule // acs_scheduler

// [shared/acs_map.vh]
// register map, field positions and timing constants for the conversion scheduler
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_ADDR_MODE        8'h07
`define ACS_ADDR_MASK        8'h08
`define ACS_ADDR_FINE        8'h09
`define ACS_ADDR_RESULT_BASE 8'h20
`define ACS_ADDR_RESULT_LAST 8'h27
`define ACS_RESET_MODE       1'b0
`define ACS_RESET_MASK       8'h00
`define ACS_RESET_FINE       3'h0
`define ACS_BIT_MODE         0
`define ACS_BIT_TEMP         7
`define ACS_NCHAN            8
`define ACS_CHAN_LAST        3'h7
`define ACS_IDLE_MS          728
`define ACS_CLK_MHZ          100
`define ACS_CYC_PER_MS       (`ACS_CLK_MHZ * 1000)
`define ACS_IDLE_CYCLES      (`ACS_IDLE_MS * `ACS_CYC_PER_MS)
// fine rate periods in microseconds, codes 1..7
`define ACS_FINE_US_1        1200
`define ACS_FINE_US_2        4800
`define ACS_FINE_US_3        9600
`define ACS_FINE_US_4        38000
`define ACS_FINE_US_5        77000
`define ACS_FINE_US_6        154000
`define ACS_FINE_US_7        614000
`define ACS_CLK_PER_US       `ACS_CLK_MHZ
`define ACS_CNT_W            27
`endif

// [tb/acs_chk.sv]
// assertions on the scheduler ports
`timescale 1ns/1ps
module acs_chk (
   input wire       clk_in,
   input wire       nrst_in,
   input wire       reg_wr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   input wire       conv_start_out,
   input wire [2:0] conv_chan_out,
   input wire [7:0] limit_fault_in,
   input wire       alert_out,
   input wire       busy_out
);
   reg [7:0] mask_q, mask_p_q;
   reg [2:0] fine_q, last_q;
   reg       mode_q, start_p_q, seen_q;
   // shadow of host writes; seen clears between passes so wrap is legal
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         {mask_q, mask_p_q, fine_q, last_q, mode_q, start_p_q, seen_q} <= 25'h0;
      end else begin
         mask_p_q  <= mask_q;
         start_p_q <= conv_start_out;
         if (reg_wr_in && reg_addr_in == 8'h07) mode_q <= reg_wdata_in[0];
         if (reg_wr_in && reg_addr_in == 8'h08) mask_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == 8'h09) fine_q <= reg_wdata_in[2:0];
         if (!busy_out) seen_q <= 1'b0;
         else if (start_p_q) seen_q <= 1'b1;
         if (start_p_q) last_q <= conv_chan_out;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   chk_idle_gap: assert property (
      $fell(busy_out) && !$past(mode_q) && $past(fine_q) == 3'h0 |-> !busy_out [*8])
      else $error("gap short");
   chk_cont_restart: assert property (
      $fell(busy_out) && $past(mode_q) && $past(fine_q) == 3'h0 && mask_q != 8'hFF
      |-> ##[1:2] busy_out) else $error("no restart");
   chk_unmapped_zero: assert property (
      reg_rd_in && (reg_addr_in < 8'h07 || (reg_addr_in > 8'h09 && reg_addr_in < 8'h20)
      || reg_addr_in > 8'h27) |=> reg_rdata_out == 8'h00) else $error("unmapped read");
   chk_mask_read: assert property (
      reg_rd_in && reg_addr_in == 8'h08 |=> reg_rdata_out == mask_q) else $error("mask read");
   chk_skip_masked: assert property (
      start_p_q |-> !mask_p_q[conv_chan_out]) else $error("masked channel converted");
   chk_masked_result: assert property (
      reg_rd_in && reg_addr_in[7:3] == 5'h04 && mask_q[reg_addr_in[2:0]]
      |=> reg_rdata_out == 8'h00) else $error("masked result");
   chk_alert_mask: assert property (
      alert_out == |(limit_fault_in & ~mask_q)) else $error("alert mismatch");
   chk_fine_gap: assert property (
      $fell(busy_out) && $past(fine_q) != 3'h0 |-> !busy_out [*8]) else $error("fine gap short");
   chk_chan_order: assert property (
      start_p_q && seen_q |-> conv_chan_out > last_q) else $error("order broken");
endmodule // acs_chk
bind acs_scheduler acs_chk u_acs_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .conv_start_out(conv_start_out), .conv_chan_out(conv_chan_out),
   .limit_fault_in(limit_fault_in), .alert_out(alert_out), .busy_out(busy_out));

// [tb/acs_conv_model.sv]
// behavioural converter answering start pulses
`timescale 1ns/1ps
module acs_conv_model (
   input  wire       clk_in,
   input  wire       start_in,
   input  wire [2:0] chan_in,
   output reg        done_out = 1'b0,
   output reg  [9:0] data_out = 10'h000
);
   integer wait_q = 0;
   reg     slow_q = 1'b0;
   // alternate quick and slow answers; data toggles outside done so stale values never match
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      data_out <= ~data_out;
      if (start_in) begin
         wait_q <= slow_q ? 4 : 1;
         slow_q <= ~slow_q;
      end else if (wait_q == 1) begin
         done_out <= 1'b1;
         data_out <= {chan_in, chan_in, 4'hC};
         wait_q   <= 0;
      end else if (wait_q > 1) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule // acs_conv_model

// [tb/tb_acs_scheduler.sv]
// self-checking bench for the conversion scheduler
`timescale 1ns/1ps
module tb_acs_scheduler;
   reg        clk = 1'b0;
   reg        nrst = 1'b0;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   reg  [7:0] addr = 8'h00;
   reg  [7:0] wdat = 8'h00;
   reg  [7:0] lim = 8'h00;
   wire [7:0] rdat;
   wire [9:0] cdat;
   wire [2:0] chan;
   wire       start, done, alert, busy;
   integer    errors = 0, num_checks = 0, i;
   // 100 MHz clock
   always #5 clk = ~clk;
   acs_scheduler u_acs_scheduler (.clk_in(clk), .nrst_in(nrst), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdat),
      .conv_start_out(start), .conv_chan_out(chan), .conv_done_in(done),
      .conv_data_in(cdat), .limit_fault_in(lim), .alert_out(alert), .busy_out(busy));
   acs_conv_model u_acs_conv_model (.clk_in(clk), .start_in(start), .chan_in(chan),
      .done_out(done), .data_out(cdat));
   task chk8(input [7:0] got, input [7:0] exp); begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end endtask
   task wr_reg(input [7:0] a, input [7:0] d); begin
      @(posedge clk) #1 {wr, addr, wdat} = {1'b1, a, d};
      @(posedge clk) #1 wr = 1'b0;
   end endtask
   task rd_chk(input [7:0] a, input [7:0] exp); begin
      @(posedge clk) #1 {rd, addr} = {1'b1, a};
      @(posedge clk) #1 rd = 1'b0;
      chk8(rdat, exp);
   end endtask
   // next end of pass; bounded so a stuck sequencer ends the run
   task wait_fall; integer n; begin
      n = 0;
      while (busy !== 1'b1 && n < 400) @(posedge clk) #1 n = n + 1;
      while (busy !== 1'b0 && n < 400) @(posedge clk) #1 n = n + 1;
      if (n >= 400) begin
         errors = errors + 1;
         $display("wrong value at %0t: pass never ended", $time);
         finish_test;
      end
   end endtask
   // idle must last far longer than 200 cycles in these modes
   task quiet; integer n, hits; begin
      hits = 0;
      for (n = 0; n < 200; n = n + 1) @(posedge clk) #1 hits = hits + (busy !== 1'b0);
      chk8(hits[7:0], 8'h00);
   end endtask
   task finish_test; begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   end endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      wr_reg(8'h07, 8'hFF);
      rd_chk(8'h07, 8'h01);
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h10, 8'h00);
      wr_reg(8'h08, 8'hFF);
      rd_chk(8'h08, 8'hFF);
      wr_reg(8'h08, 8'h00);
      $display("test registers done");
      wait_fall;
      wait_fall;
      @(posedge clk) #1 chk8({7'h00, busy}, 8'h01);
      for (i = 0; i < 8; i = i + 1) rd_chk(8'h20 + i[7:0], {i[2:0], i[2:0], 2'h3});
      wr_reg(8'h08, 8'hA5);
      wait_fall;
      wait_fall;
      for (i = 0; i < 8; i = i + 1)
         rd_chk(8'h20 + i[7:0], (8'hA5 & (8'h01 << i)) ? 8'h00 : {i[2:0], i[2:0], 2'h3});
      @(posedge clk) #1 lim = 8'h85;
      #1 chk8({7'h00, alert}, 8'h00);
      @(posedge clk) #1 lim = 8'h02;
      #1 chk8({7'h00, alert}, 8'h01);
      $display("test mask done");
      wr_reg(8'h09, 8'h01);
      rd_chk(8'h09, 8'h01);
      wait_fall;
      quiet;
      @(posedge clk) #1 nrst = 1'b0;
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      rd_chk(8'h09, 8'h00);
      wait_fall;
      quiet;
      $display("test rate done");
      finish_test;
   end
endmodule // tb_acs_scheduler
